// *** tce_pkg.sv ***
// Constants, opcodes, halt codes and register map for the teaching CPU execute unit
// -----------------------------------------------------------------------------
// Overview of operation
// - Opcode in bits 15:12, then two-bit selectors, then function or byte argument.
// - While executing, the instruction counter already points at the next instruction.
// - Opcode 0x5 stops execution and leaves the machine halted.
// - Halt with any nonzero register selector is malformed.
// - Halt function field is the 6-bit halt code; zero means normal stop.
// - Unimplemented instruction halts with 0x01, malformed encoding with 0x02.
// - An odd instruction counter halts with 0x03.
// - A memory access beyond installed memory halts with 0x04.
// - Hardware never raises 0x20; it only appears through a program halt.
// - Opcode 0x6 combines second and third selector registers; 0x0 add, 0x1 subtract.
// - Opcode 0x6 functions 0x4, 0x5, 0x6 give AND, OR, XOR.
// - Opcode 0x6 functions 0x8 to 0xb shift the first source register.
// - Constant shift kind from function bits 5:4: lsl, lsr, asl, asr.
// - Constant shift distance is function bits 3:0 plus one.
// - Constant shift with a nonzero third selector is malformed.
// - Opcodes 0x8 to 0xb add, AND, OR, XOR with sign-extended byte.
// - Opcode 0xc is always an illegal instruction error halt.
// - Opcode 0xd replaces the destination's upper byte, keeps the lower byte.
// - Load-high-byte with a nonzero second selector is malformed.
// - Opcode 0xe stores the first register at second register plus byte.
// - Opcode 0xf loads the word at that address into the first register.
// -----------------------------------------------------------------------------
package tce_pkg;
    // Instruction fields
    localparam int OP_MSB = 15;
    localparam int OP_LSB = 12;
    localparam int RX_LSB = 10;
    localparam int RA_LSB = 8;
    localparam int RB_LSB = 6;
    // Opcodes
    localparam logic [3:0] OP_HALT = 4'h5;
    localparam logic [3:0] OP_ARI = 4'h6;
    localparam logic [3:0] OP_SFT = 4'h7;
    localparam logic [3:0] OP_ADC = 4'h8;
    localparam logic [3:0] OP_ANC = 4'h9;
    localparam logic [3:0] OP_ORC = 4'ha;
    localparam logic [3:0] OP_XOC = 4'hb;
    localparam logic [3:0] OP_ILL = 4'hc;
    localparam logic [3:0] OP_LCH = 4'hd;
    localparam logic [3:0] OP_STO = 4'he;
    localparam logic [3:0] OP_LOA = 4'hf;
    // Arithmetic functions
    localparam logic [5:0] FN_ADD = 6'h00;
    localparam logic [5:0] FN_SUB = 6'h01;
    localparam logic [5:0] FN_AND = 6'h04;
    localparam logic [5:0] FN_OR = 6'h05;
    localparam logic [5:0] FN_XOR = 6'h06;
    localparam logic [5:0] FN_LSL = 6'h08;
    localparam logic [5:0] FN_LSR = 6'h09;
    localparam logic [5:0] FN_ASL = 6'h0a;
    localparam logic [5:0] FN_ASR = 6'h0b;
    // Halt codes raised by hardware
    localparam logic [5:0] HC_UNIMPL = 6'h01;
    localparam logic [5:0] HC_FORMAT = 6'h02;
    localparam logic [5:0] HC_ODD_IC = 6'h03;
    localparam logic [5:0] HC_ADDR = 6'h04;
    // APB register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_IC = 8'h08;
    localparam logic [7:0] REG_GPR0 = 8'h10;
    localparam logic [7:0] REG_GPR3 = 8'h1c;
    // Field positions
    localparam int CTRL_START = 0;
    localparam int STAT_RUN = 0;
    localparam int STAT_HALT = 1;
    localparam int STAT_CODE = 8;
    // Reset values
    localparam logic [15:0] IC_RESET = 16'h0000;
    localparam logic [15:0] WORD_ZERO = 16'h0000;
    localparam logic [5:0] CODE_RESET = 6'h00;
    // Control sequence
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_FETCH,
        ST_EXEC,
        ST_MEM,
        ST_HALT
    } tce_state_e;
endpackage

// *** tce_execute_unit.sv ***
// Fetch, decode and execute unit of the teaching CPU with an APB register port
`timescale 1ns/100ps
module tce_execute_unit
    import tce_pkg::*;
#(
    parameter int MEM_BYTES = 256
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Word memory port
    output logic mem_req,
    output logic mem_we,
    output logic [15:0] mem_addr,
    output logic [15:0] mem_wdata,
    input wire logic [15:0] mem_rdata,
    input wire logic mem_ack,
    // Machine status
    output logic running,
    output logic halted,
    output logic [5:0] halt_code
);

    // -------------------------------------------------------------------------
    // Elaboration checks
    // -------------------------------------------------------------------------
    // The word at the top address needs addr+1, so two bytes is the least
    if (MEM_BYTES < 2 || MEM_BYTES > 65536) begin : g_bad_size
        $error("MEM_BYTES must lie between 2 and 65536");
    end

    localparam logic [16:0] MEM_TOP = 17'(MEM_BYTES);

    // -------------------------------------------------------------------------
    // State
    // -------------------------------------------------------------------------
    tce_state_e state;
    logic [15:0] ic;
    logic [15:0] ir;
    logic [15:0] gpr [4];
    logic [15:0] mem_addr_q;
    logic [1:0] load_dst;

    // APB decode
    logic apb_setup;
    logic apb_wr;
    logic start_req;
    logic sw_access;
    logic [1:0] gpr_sel;
    logic gpr_hit;
    logic mapped;

    // Decode results
    logic [3:0] op;
    logic [1:0] rx;
    logic [1:0] ra;
    logic [1:0] rb;
    logic [5:0] fn;
    logic [15:0] sext;
    logic [15:0] va;
    logic [15:0] vb;
    logic [15:0] vx;
    logic [15:0] ea;
    logic ex_wr;
    logic [15:0] ex_val;
    logic ex_halt;
    logic [5:0] ex_code;
    logic ex_mem;
    logic ex_store;

    // Fetch address checks
    logic ic_odd;
    logic ic_oob;

    // -------------------------------------------------------------------------
    // Helpers
    // -------------------------------------------------------------------------
    // Word at addr also uses addr+1, so both bytes must be installed
    function automatic logic in_range(input logic [15:0] a);
        in_range = ({1'b0, a} + 17'h00001) < MEM_TOP;
    endfunction

    // Kind bit 0 picks right, bit 1 arithmetic; distances past 15 empty the word, or fill it with the sign bit for asr
    function automatic logic [15:0] shifter(input logic [1:0] kind,
                                            input logic [15:0] v,
                                            input logic [4:0] amt);
        logic [15:0] r;
        r = WORD_ZERO;
        case (kind)
            2'b00: r = v << amt;
            2'b01: r = v >> amt;
            2'b10: r = v << amt;
            2'b11: r = 16'($signed(v) >>> amt);
            default: r = WORD_ZERO;
        endcase
        shifter = r;
    endfunction

    // -------------------------------------------------------------------------
    // Instruction decode and execute datapath
    // -------------------------------------------------------------------------
    // Field split of the held instruction
    assign op = ir[OP_MSB:OP_LSB];
    assign rx = ir[RX_LSB+1:RX_LSB];
    assign ra = ir[RA_LSB+1:RA_LSB];
    assign rb = ir[RB_LSB+1:RB_LSB];
    assign fn = ir[5:0];
    assign sext = {{8{ir[7]}}, ir[7:0]};
    assign va = gpr[ra];
    assign vb = gpr[rb];
    assign vx = gpr[rx];
    // Effective address wraps like every other sum
    assign ea = va + sext;

    // One combinational decode; the controller only acts on its outcome
    always_comb begin
        ex_wr = 1'b0;
        ex_val = WORD_ZERO;
        ex_halt = 1'b0;
        ex_code = CODE_RESET;
        ex_mem = 1'b0;
        ex_store = 1'b0;
        case (op)
            OP_HALT: begin
                ex_halt = 1'b1;
                if (rx != 2'b00 || ra != 2'b00 || rb != 2'b00) begin
                    ex_code = HC_FORMAT;
                end else begin
                    ex_code = fn;
                end
            end
            OP_ARI: begin
                ex_wr = 1'b1;
                case (fn)
                    FN_ADD: ex_val = va + vb;
                    FN_SUB: ex_val = va - vb;
                    FN_AND: ex_val = va & vb;
                    FN_OR: ex_val = va | vb;
                    FN_XOR: ex_val = va ^ vb;
                    FN_LSL, FN_LSR, FN_ASL, FN_ASR: begin
                        // Saturate the distance at 16 so a huge count still empties the word, or sign-fills it for asr
                        ex_val = shifter(fn[1:0], va,
                                         (vb > 16'h0010) ? 5'h10 : vb[4:0]);
                    end
                    default: begin
                        ex_wr = 1'b0;
                        ex_halt = 1'b1;
                        ex_code = HC_FORMAT;
                    end
                endcase
            end
            OP_SFT: begin
                if (rb != 2'b00) begin
                    ex_halt = 1'b1;
                    ex_code = HC_FORMAT;
                end else begin
                    ex_wr = 1'b1;
                    ex_val = shifter(fn[5:4], va,
                                     {1'b0, fn[3:0]} + 5'h01);
                end
            end
            OP_ADC: begin
                ex_wr = 1'b1;
                ex_val = va + sext;
            end
            OP_ANC: begin
                ex_wr = 1'b1;
                ex_val = va & sext;
            end
            OP_ORC: begin
                ex_wr = 1'b1;
                ex_val = va | sext;
            end
            OP_XOC: begin
                ex_wr = 1'b1;
                ex_val = va ^ sext;
            end
            OP_ILL: begin
                ex_halt = 1'b1;
                ex_code = HC_UNIMPL;
            end
            OP_LCH: begin
                if (ra != 2'b00) begin
                    ex_halt = 1'b1;
                    ex_code = HC_FORMAT;
                end else begin
                    ex_wr = 1'b1;
                    ex_val = {ir[7:0], vx[7:0]};
                end
            end
            OP_STO, OP_LOA: begin
                if (!in_range(ea)) begin
                    ex_halt = 1'b1;
                    ex_code = HC_ADDR;
                end else begin
                    ex_mem = 1'b1;
                    ex_store = (op == OP_STO);
                end
            end
            default: begin
                // Branches and call live outside this unit
                ex_halt = 1'b1;
                ex_code = HC_UNIMPL;
            end
        endcase
    end

    // Fetch checks on the instruction counter
    assign ic_odd = ic[0];
    assign ic_oob = !in_range(ic);

    // -------------------------------------------------------------------------
    // APB decode
    // -------------------------------------------------------------------------
    // Registers act at the access edge, when the registered pready is high
    assign apb_setup = psel && !penable;
    assign apb_wr = psel && penable && pready && pwrite && !pslverr;
    assign sw_access = (state == ST_IDLE) || (state == ST_HALT);
    assign gpr_hit = (paddr >= REG_GPR0) && (paddr <= REG_GPR3) && (paddr[1:0] == 2'b00);
    assign gpr_sel = 2'((paddr - REG_GPR0) >> 2);
    assign mapped = (paddr == REG_CTRL) || (paddr == REG_STATUS) ||
                    (paddr == REG_IC) || gpr_hit;
    assign start_req = apb_wr && (paddr == REG_CTRL) && pwdata[CTRL_START] && sw_access;

    // Answer flops: one wait-free access phase, error on unmapped addresses
    always_ff @(posedge core_clk) begin
        if (srst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else if (apb_setup) begin
            pready <= 1'b1;
            pslverr <= !mapped;
            prdata <= 32'h00000000;
            if (!pwrite) begin
                if (paddr == REG_STATUS) begin
                    prdata[STAT_RUN] <= running;
                    prdata[STAT_HALT] <= halted;
                    prdata[STAT_CODE+5:STAT_CODE] <= halt_code;
                end else if (paddr == REG_IC) begin
                    prdata[15:0] <= ic;
                end else if (gpr_hit) begin
                    prdata[15:0] <= gpr[gpr_sel];
                end
            end
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // -------------------------------------------------------------------------
    // Sequencer
    // -------------------------------------------------------------------------
    // A start request from software wins only while the machine is stopped
    always_ff @(posedge core_clk) begin
        if (srst) begin
            state <= ST_IDLE;
        end else begin
            case (state)
                ST_IDLE, ST_HALT: begin
                    if (start_req) begin
                        state <= ST_FETCH;
                    end
                end
                ST_FETCH: begin
                    if (!mem_req && (ic_odd || ic_oob)) begin
                        state <= ST_HALT;
                    end else if (mem_req && mem_ack) begin
                        state <= ST_EXEC;
                    end
                end
                ST_EXEC: begin
                    if (ex_halt) begin
                        state <= ST_HALT;
                    end else if (ex_mem) begin
                        state <= ST_MEM;
                    end else begin
                        state <= ST_FETCH;
                    end
                end
                ST_MEM: begin
                    if (mem_req && mem_ack) begin
                        state <= ST_FETCH;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Instruction counter: bumped at fetch so execution sees the next address
    always_ff @(posedge core_clk) begin
        if (srst) begin
            ic <= IC_RESET;
            ir <= WORD_ZERO;
        end else if (state == ST_FETCH && mem_req && mem_ack) begin
            ir <= mem_rdata;
            ic <= ic + 16'h0002;
        end else if (apb_wr && paddr == REG_IC && sw_access) begin
            ic <= pwdata[15:0];
        end
    end

    // Register file; r0 is held at zero, so writes to it are dropped
    always_ff @(posedge core_clk) begin
        if (srst) begin
            for (int i = 0; i < 4; i++) begin
                gpr[i] <= WORD_ZERO;
            end
        end else if (state == ST_EXEC && ex_wr && rx != 2'b00) begin
            gpr[rx] <= ex_val;
        end else if (state == ST_MEM && mem_req && mem_ack && !mem_we &&
                     load_dst != 2'b00) begin
            gpr[load_dst] <= mem_rdata;
        end else if (apb_wr && gpr_hit && sw_access && gpr_sel != 2'b00) begin
            gpr[gpr_sel] <= pwdata[15:0];
        end
    end

    // Memory request: held until the memory acknowledges
    always_ff @(posedge core_clk) begin
        if (srst) begin
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            mem_addr_q <= WORD_ZERO;
            mem_wdata <= WORD_ZERO;
            load_dst <= 2'b00;
        end else if (mem_req) begin
            if (mem_ack) begin
                mem_req <= 1'b0;
                mem_we <= 1'b0;
            end
        end else if (state == ST_FETCH && !ic_odd && !ic_oob) begin
            mem_req <= 1'b1;
            mem_we <= 1'b0;
            mem_addr_q <= ic;
        end else if (state == ST_EXEC && !ex_halt && ex_mem) begin
            mem_req <= 1'b1;
            mem_we <= ex_store;
            mem_addr_q <= ea;
            mem_wdata <= vx;
            load_dst <= rx;
        end
    end

    assign mem_addr = mem_addr_q;

    // Status flops; the code keeps its value until the next start
    always_ff @(posedge core_clk) begin
        if (srst) begin
            running <= 1'b0;
            halted <= 1'b0;
            halt_code <= CODE_RESET;
        end else if (start_req) begin
            running <= 1'b1;
            halted <= 1'b0;
            halt_code <= CODE_RESET;
        end else if (state == ST_FETCH && !mem_req && ic_odd) begin
            running <= 1'b0;
            halted <= 1'b1;
            halt_code <= HC_ODD_IC;
        end else if (state == ST_FETCH && !mem_req && ic_oob) begin
            running <= 1'b0;
            halted <= 1'b1;
            halt_code <= HC_ADDR;
        end else if (state == ST_EXEC && ex_halt) begin
            running <= 1'b0;
            halted <= 1'b1;
            halt_code <= ex_code;
        end
    end

endmodule // tce_execute_unit

// *** tce_execute_unit_chk.sv ***
// Port-level concurrent checks for the teaching CPU execute unit
`timescale 1ns/100ps
module tce_execute_unit_chk
    import tce_pkg::*;
#(
    parameter int MEM_BYTES = 256
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Memory
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [15:0] mem_addr,
    input wire logic [15:0] mem_wdata,
    input wire logic [15:0] mem_rdata,
    input wire logic mem_ack,
    // Status
    input wire logic running,
    input wire logic halted,
    input wire logic [5:0] halt_code
);
    logic start_wr;
    // Start request completing on the bus this cycle
    assign start_wr = psel && penable && pready && pwrite && paddr == REG_CTRL && pwdata[0];
    // -------------------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------------------
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (srst);
    property p_excl; !(running && halted); endproperty
    a_excl: assert property (p_excl) else $error("running while halted");
    property p_stop; $rose(halted) |-> $fell(running); endproperty
    a_stop: assert property (p_stop) else $error("halt without leaving run");
    property p_stay; halted && !start_wr |=> halted; endproperty
    a_stay: assert property (p_stay) else $error("halt left without start");
    property p_quiet; halted |-> !mem_req; endproperty
    a_quiet: assert property (p_quiet) else $error("memory busy while halted");
    property p_code; halted && $past(halted) |-> $stable(halt_code); endproperty
    a_code: assert property (p_code) else $error("halt code moved");
    property p_start; start_wr && !running |=> running && !halted && halt_code == 6'h00; endproperty
    a_start: assert property (p_start) else $error("start not taken");
    property p_hold; mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we) && $stable(mem_wdata); endproperty
    a_hold: assert property (p_hold) else $error("memory request changed");
    property p_gap; mem_req && mem_ack |=> !mem_req; endproperty
    a_gap: assert property (p_gap) else $error("no idle after access");
    property p_range; mem_req |-> ({1'b0, mem_addr} + 17'h1) < MEM_BYTES; endproperty
    a_range: assert property (p_range) else $error("access beyond memory");
    property p_ans; psel && !penable |=> pready ##1 !pready; endproperty
    a_ans: assert property (p_ans) else $error("bus answer late or long");
endmodule // tce_execute_unit_chk

bind tce_execute_unit tce_execute_unit_chk #(.MEM_BYTES(MEM_BYTES)) chk_i (
    .core_clk(core_clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack), .running(running), .halted(halted),
    .halt_code(halt_code));

// *** tce_mem_model.sv ***
// Byte-addressed word memory that answers the execute unit after a random stall
`timescale 1ns/100ps
module tce_mem_model #(
    parameter int MEM_BYTES = 64
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // Request
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [15:0] mem_addr,
    input wire logic [15:0] mem_wdata,
    // Answer
    output logic [15:0] mem_rdata,
    output logic mem_ack
);
    logic [7:0] mem [MEM_BYTES];
    int stall;
    initial begin
        mem_ack = 1'b0;
        mem_rdata = 16'h5a5a;
        stall = 0;
    end
    // One word per request; stalls of zero to three cycles exercise the wait path
    always @(posedge core_clk) begin
        mem_ack <= 1'b0;
        mem_rdata <= ~mem_rdata; // Never leave a stale word on the bus
        if (mem_req && !mem_ack && !srst) begin
            if (stall > 0) begin
                stall <= stall - 1;
            end else begin
                mem_ack <= 1'b1;
                stall <= $urandom % 4;
                if (mem_we) begin
                    mem[mem_addr] <= mem_wdata[7:0];
                    mem[mem_addr + 16'h1] <= mem_wdata[15:8];
                end else begin
                    mem_rdata <= {mem[mem_addr + 16'h1], mem[mem_addr]};
                end
            end
        end
    end
endmodule // tce_mem_model

// *** tce_execute_unit_tb_top.sv ***
// Self-checking bench for the teaching CPU execute unit
`timescale 1ns/100ps
module tce_execute_unit_tb_top;
    import tce_pkg::*;
    localparam int MB = 64;
    localparam logic [5:0] FNS [9] = '{6'h00, 6'h01, 6'h04, 6'h05, 6'h06, 6'h08, 6'h09, 6'h0a, 6'h0b};
    localparam logic [15:0] PROG [8] = '{16'h8485, 16'hd492, 16'h8803, 16'h6d80, 16'h7933,
        16'hec3e, 16'hf43e, 16'h502a};
    localparam logic [15:0] BAD_IW [10] = '{16'h5400, 16'h6542, 16'h7540, 16'hd500, 16'hc123,
        16'h0000, 16'hf47f, 16'he43f, 16'h5020, 16'h2345};
    localparam logic [5:0] BAD_HC [10] = '{6'h02, 6'h02, 6'h02, 6'h02, 6'h01, 6'h03, 6'h04,
        6'h04, 6'h20, 6'h01};
    logic core_clk, srst, psel, penable, pwrite, pready, pslverr;
    logic mem_req, mem_we, mem_ack, running, halted;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [15:0] mem_addr, mem_wdata, mem_rdata, iw, a, b;
    logic [5:0] halt_code;
    logic [32:0] q_rd [$];
    logic [5:0] q_hc [$];
    int n_fail, n_compared;

    tce_execute_unit #(.MEM_BYTES(MB)) dut (.core_clk(core_clk), .srst(srst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .mem_req(mem_req), .mem_we(mem_we),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
        .running(running), .halted(halted), .halt_code(halt_code));
    tce_mem_model #(.MEM_BYTES(MB)) mem_i (.core_clk(core_clk), .srst(srst), .mem_req(mem_req),
        .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
        .mem_ack(mem_ack));

    // -------------------------------------------------------------------------
    // Tasks
    // -------------------------------------------------------------------------
    task automatic close_out();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk_rd(input logic [32:0] e, input logic [32:0] g);
        n_compared++;
        if (g !== e) begin
            n_fail++;
            $display("BAD read expected %h seen %h", e, g);
        end
    endtask
    task automatic chk_hc(input logic [5:0] e, input logic [5:0] g);
        n_compared++;
        if (g !== e) begin
            n_fail++;
            $display("BAD halt_code expected %h seen %h", e, g);
        end
    endtask
    // Setup, then access until pready; one idle edge keeps drivers from colliding
    task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            n_fail++;
            close_out();
        end
        @(posedge core_clk);
    endtask
    task automatic rd(input logic [7:0] ad, input logic [32:0] e);
        q_rd.push_back(e);
        apb(1'b0, ad, 32'h0);
    endtask
    task automatic put(input int ad, input logic [15:0] w);
        mem_i.mem[ad] = w[7:0];
        mem_i.mem[ad + 1] = w[15:8];
    endtask
    task automatic run(input logic [15:0] ic, input logic [5:0] code);
        int n;
        n = 0;
        q_hc.push_back(code);
        apb(1'b1, REG_IC, {16'h0, ic});
        apb(1'b1, REG_CTRL, 32'h1);
        while (halted !== 1'b1 && n < 500) begin
            @(posedge core_clk);
            n++;
        end
        if (n >= 500) begin
            n_fail++;
            close_out();
        end
    endtask
    function automatic logic [15:0] ref_op(input logic [15:0] w, input logic [15:0] x,
        input logic [15:0] y);
        logic [15:0] k;
        int d;
        k = {{8{w[7]}}, w[7:0]};
        d = (y > 16'd16) ? 16 : int'(y);
        // Constant shift: distance from the low four bits, kind mapped onto the shift functions
        if (w[15:12] == OP_SFT) begin
            d = int'(w[3:0]) + 1;
            w[5:0] = {4'h2, w[5:4]};
        end
        case (w[15:12])
            OP_ADC: return x + k;
            OP_ANC: return x & k;
            OP_ORC: return x | k;
            OP_XOC: return x ^ k;
            default: ;
        endcase
        case (w[5:0])
            FN_ADD: return x + y;
            FN_SUB: return x - y;
            FN_AND: return x & y;
            FN_OR: return x | y;
            FN_XOR: return x ^ y;
            FN_LSR: return x >> d;
            FN_ASR: return 16'($signed(x) >>> d);
            default: return x << d;
        endcase
    endfunction

    // Clock
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // Result watcher: each bus read and each halt takes the oldest note
    always @(posedge core_clk) begin
        if (psel && penable && pready && !pwrite) begin
            chk_rd(q_rd.pop_front(), {pslverr, prdata});
        end
        if ($rose(halted)) begin
            chk_hc(q_hc.pop_front(), halt_code);
        end
    end
    // Main sequence
    initial begin
        srst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (10) @(posedge core_clk);
        srst <= 1'b0;
        @(posedge core_clk);
        void'($urandom(32'h1a55));
        for (int i = 0; i < 8; i++) put(2 * i, PROG[i]);
        run(16'h0, 6'h2a);
        rd(REG_GPR0 + 8'h4, 33'h9288);
        rd(REG_GPR0 + 8'h8, 33'hf928);
        rd(REG_GPR3, 33'h9288);
        rd(REG_IC, 33'h10);
        rd(REG_STATUS, 33'h2a02);
        rd(8'h40, {1'b1, 32'h0});
        // Every arithmetic function, byte-constant opcode and constant shift kind, random operands
        for (int i = 0; i < 17; i++) begin
            a = 16'($urandom);
            b = (i > 4 && i < 9) ? 16'($urandom % 20) : 16'($urandom);
            iw = (i < 9) ? {OP_ARI, 6'b110110, FNS[i]} : {OP_ADC + 4'(i - 9), 4'b1101, 8'($urandom)};
            if (i > 12) begin
                iw = {OP_SFT, 6'b110100, 2'(i - 13), 4'($urandom)};
            end
            apb(1'b1, REG_GPR0 + 8'h4, {16'h0, a});
            apb(1'b1, REG_GPR0 + 8'h8, {16'h0, b});
            put(0, iw);
            put(2, {OP_HALT, 12'h000});
            run(16'h0, 6'h00);
            rd(REG_GPR3, {17'h0, ref_op(iw, a, b)});
            rd(REG_IC, 33'h4);
        end
        // Malformed, unused, odd counter, out-of-range and program-raised halts
        for (int i = 0; i < 10; i++) begin
            put(0, BAD_IW[i]);
            run((i == 5) ? 16'h1 : 16'h0, BAD_HC[i]);
        end
        close_out();
    end
endmodule // tce_execute_unit_tb_top
